// >>> core/port1_link_strap_defaults.sv
// port1_link_strap_defaults: latches the port 1 soft straps, keeps the
// EEPROM overrides, and holds the strap-derived PHY and flow-control registers.
// assumes synchronous strap pins, a classic Wishbone master, and a loader
// that pulses eeprom_load_i with a full strap set.
`timescale 1ns/1ps
`default_nettype none

module port1_link_strap_defaults (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reset_pin_low_i,
    input wire logic port1_speed_input_i,
    input wire logic port1_duplex_input_i,
    input wire logic port1_backpressure_input_i,
    input wire logic port1_pause_enable_input_i,
    input wire logic eeprom_present_i,
    input wire logic eeprom_load_i,
    input wire strap_defaults_pkg::strap_set_t eeprom_straps_i,
    input wire logic digital_reset_i,
    input wire logic reload_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [strap_defaults_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [strap_defaults_pkg::DAT_W-1:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [strap_defaults_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic phy_rate_select_low_bit_o,
    output logic phy_half_full_bit_o,
    output logic port1_backpressure_enable_o,
    output logic port1_tx_pause_active_o,
    output logic port1_rx_pause_active_o
);
    import strap_defaults_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // reset hold and strap latching

    logic hold;
    logic hold_r;
    logic release_evt;
    strap_set_t pins;
    strap_set_t latched_r;
    strap_set_t active_r;
    strap_set_t active_nxt;
    logic restore_evt;
    logic load_evt;
    logic cmd_digital;
    logic cmd_reload;

    assign hold = rst_i | ~reset_pin_low_i;
    assign release_evt = hold_r & ~hold;
    assign pins = '{speed: port1_speed_input_i, duplex: port1_duplex_input_i,
                    backpressure: port1_backpressure_input_i,
                    pause: port1_pause_enable_input_i};
    // restore only when no valid EEPROM will reload
    assign restore_evt = (digital_reset_i | reload_i | cmd_digital | cmd_reload)
                         & ~eeprom_present_i;
    assign load_evt = release_evt | restore_evt | (eeprom_load_i & ~hold);

    always_comb begin
        active_nxt = active_r;
        if (release_evt) begin
            active_nxt = pins;
        end else if (eeprom_load_i) begin
            active_nxt = eeprom_straps_i;
        end else if (restore_evt) begin
            active_nxt = latched_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_r <= 1'b1;
        end else begin
            hold_r <= hold;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latched_r <= STRAP_TIE_OFF;
        end else if (release_evt) begin
            latched_r <= pins;
        end
    end

    always_ff @(posedge clk_i) begin
        if (hold) begin
            active_r <= STRAP_TIE_OFF;
        end else begin
            active_r <= active_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // derived images and register file

    reg_image_t image;
    reg_image_t reset_image;
    logic [REG_W-1:0] basic_r;
    logic [REG_W-1:0] advert_r;
    logic [REG_W-1:0] modes_r;
    logic [REG_W-1:0] flow_r;

    strap_image_map u_map (
        .straps_i(active_nxt),
        .image_o(image)
    );

    strap_image_map u_tie_map (
        .straps_i(STRAP_TIE_OFF),
        .image_o(reset_image)
    );

    // wishbone decode
    logic req;
    logic ack_r;
    logic wr;
    logic [REG_W-1:0] wmask;
    logic hit_basic;
    logic hit_advert;
    logic hit_modes;
    logic hit_flow;
    logic hit_status;
    logic hit_cmd;
    logic [REG_W-1:0] wdata;

    assign req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr = req & wb_we_i;
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign hit_basic = (wb_adr_i == OFS_BASIC);
    assign hit_advert = (wb_adr_i == OFS_ADVERT);
    assign hit_modes = (wb_adr_i == OFS_MODES);
    assign hit_flow = (wb_adr_i == OFS_FLOW);
    assign hit_status = (wb_adr_i == OFS_STATUS);
    assign hit_cmd = (wb_adr_i == OFS_CMD);
    assign wdata = wb_dat_i[REG_W-1:0];
    assign cmd_digital = wr & hit_cmd & wb_sel_i[0] & wdata[CMD_DIGITAL_BIT];
    assign cmd_reload = wr & hit_cmd & wb_sel_i[0] & wdata[CMD_RELOAD_BIT];

    // merge a software write into one register under byte lanes
    function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] cur,
                                                input logic [REG_W-1:0] val,
                                                input logic [REG_W-1:0] msk);
        merge = (cur & ~msk) | (val & msk);
    endfunction

    // a release, restore or EEPROM load wins over a write in the same cycle, writes win otherwise
    always_ff @(posedge clk_i) begin
        if (hold) begin
            basic_r <= reset_image.basic;
            advert_r <= reset_image.advert;
            modes_r <= reset_image.modes;
            flow_r <= reset_image.flow;
        end else if (load_evt) begin
            basic_r <= image.basic;
            advert_r <= image.advert;
            modes_r <= image.modes;
            flow_r <= image.flow;
        end else begin
            if (wr & hit_basic) begin
                basic_r <= merge(basic_r, wdata, wmask);
            end
            if (wr & hit_advert) begin
                advert_r <= merge(advert_r, wdata, wmask);
            end
            if (wr & hit_modes) begin
                modes_r <= merge(modes_r, wdata, wmask);
            end
            if (wr & hit_flow) begin
                flow_r <= merge(flow_r, wdata, wmask);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path and acknowledge

    logic [REG_W-1:0] status_word;
    logic [REG_W-1:0] rd_word;
    logic [DAT_W-1:0] rdata_r;

    always_comb begin
        status_word = '0;
        status_word[STAT_LATCHED_LSB +: 4] = latched_r;
        status_word[STAT_ACTIVE_LSB +: 4] = active_r;
        status_word[STAT_EEPROM_BIT] = eeprom_present_i;
    end

    // unmapped offsets and the command register read as zero
    assign rd_word = hit_basic ? basic_r :
                     hit_advert ? advert_r :
                     hit_modes ? modes_r :
                     hit_flow ? flow_r :
                     hit_status ? status_word : '0;

    // one wait state, ack drops the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r <= req;
            if (req) begin
                rdata_r <= {{(DAT_W-REG_W){1'b0}}, rd_word};
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // register bits driving the port

    assign phy_rate_select_low_bit_o = basic_r[BASIC_RATE_BIT];
    assign phy_half_full_bit_o = basic_r[BASIC_DUPLEX_BIT];
    assign port1_backpressure_enable_o = flow_r[FLOW_BP_BIT];
    // pause enables gated by manual select
    assign port1_tx_pause_active_o = flow_r[FLOW_MANUAL_BIT] & flow_r[FLOW_TX_BIT];
    assign port1_rx_pause_active_o = flow_r[FLOW_MANUAL_BIT] & flow_r[FLOW_RX_BIT];

endmodule // port1_link_strap_defaults

`default_nettype wire

// >>> core/strap_defaults_pkg.sv
// strap_defaults_pkg: types, register offsets, field positions and reset values
// for the port 1 strap-default block.
// assumes a 32-bit classic Wishbone register bus with 16-bit registers.
package strap_defaults_pkg;

    // one set of soft-strap values in force for port 1
    typedef struct packed {
        logic speed;
        logic duplex;
        logic backpressure;
        logic pause;
    } strap_set_t;

    // register images derived from a strap set
    typedef struct packed {
        logic [15:0] basic;
        logic [15:0] advert;
        logic [15:0] modes;
        logic [15:0] flow;
    } reg_image_t;

    // tie-off values of the four straps
    localparam strap_set_t STRAP_TIE_OFF = '{speed: 1'b1, duplex: 1'b1,
                                              backpressure: 1'b1, pause: 1'b1};

    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int REG_W = 16;

    // register byte offsets
    localparam logic [ADR_W-1:0] OFS_BASIC = 8'h00;
    localparam logic [ADR_W-1:0] OFS_ADVERT = 8'h04;
    localparam logic [ADR_W-1:0] OFS_MODES = 8'h08;
    localparam logic [ADR_W-1:0] OFS_FLOW = 8'h0c;
    localparam logic [ADR_W-1:0] OFS_STATUS = 8'h10;
    localparam logic [ADR_W-1:0] OFS_CMD = 8'h14;

    // port1_phy_basic_control fields
    localparam int BASIC_RATE_BIT = 13;
    localparam int BASIC_DUPLEX_BIT = 8;
    // portx_negotiation_advert fields
    localparam int ADV_10FD_BIT = 6;
    localparam int ADV_10HD_BIT = 5;
    // portx_phy_special_modes field
    localparam int MODES_LSB = 5;
    localparam int MODES_W = 3;
    // port1_manual_flow_control fields
    localparam int FLOW_BP_BIT = 0;
    localparam int FLOW_RX_BIT = 1;
    localparam int FLOW_TX_BIT = 2;
    localparam int FLOW_MANUAL_BIT = 3;
    // command register fields (write one to act)
    localparam int CMD_DIGITAL_BIT = 0;
    localparam int CMD_RELOAD_BIT = 1;
    // status register fields
    localparam int STAT_LATCHED_LSB = 0;
    localparam int STAT_ACTIVE_LSB = 4;
    localparam int STAT_EEPROM_BIT = 8;

    // special-mode encodings: {1'b0, rate, duplex}
    localparam logic [MODES_W-1:0] MODE_10HD = 3'h0;
    localparam logic [MODES_W-1:0] MODE_10FD = 3'h1;
    localparam logic [MODES_W-1:0] MODE_100HD = 3'h2;
    localparam logic [MODES_W-1:0] MODE_100FD = 3'h3;

    // bits of the images not steered by any strap
    localparam logic [REG_W-1:0] BASIC_BASE = 16'h0000;
    localparam logic [REG_W-1:0] ADVERT_BASE = 16'h0001;
    localparam logic [REG_W-1:0] MODES_BASE = 16'h0000;
    localparam logic [REG_W-1:0] FLOW_BASE = 16'h0000;

endpackage

// >>> core/strap_image_map.sv
// strap_image_map: turns one strap set into the four register images.
// purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none

module strap_image_map (
    input wire strap_defaults_pkg::strap_set_t straps_i,
    output var strap_defaults_pkg::reg_image_t image_o
);
    import strap_defaults_pkg::*;

    logic [MODES_W-1:0] mode_sel;
    logic [REG_W-1:0] basic_img;
    logic [REG_W-1:0] advert_img;
    logic [REG_W-1:0] modes_img;
    logic [REG_W-1:0] flow_img;

    assign mode_sel = straps_i.speed ? (straps_i.duplex ? MODE_100FD : MODE_100HD)
                                     : (straps_i.duplex ? MODE_10FD : MODE_10HD);

    always_comb begin
        basic_img = BASIC_BASE;
        basic_img[BASIC_RATE_BIT] = straps_i.speed;
        basic_img[BASIC_DUPLEX_BIT] = straps_i.duplex;
        advert_img = ADVERT_BASE;
        advert_img[ADV_10FD_BIT] = straps_i.duplex & ~straps_i.speed;
        advert_img[ADV_10HD_BIT] = ~straps_i.speed;
        modes_img = MODES_BASE;
        modes_img[MODES_LSB +: MODES_W] = mode_sel;
        flow_img = FLOW_BASE;
        flow_img[FLOW_BP_BIT] = straps_i.backpressure;
        flow_img[FLOW_RX_BIT] = straps_i.pause;
        flow_img[FLOW_TX_BIT] = straps_i.pause;
    end

    assign image_o = '{basic: basic_img, advert: advert_img, modes: modes_img, flow: flow_img};

endmodule // strap_image_map

`default_nettype wire

// >>> tb/strap_defaults_assertions.sv
// strap_defaults_assertions: port-level checks of the strap block.
// assumes a bind onto port1_link_strap_defaults; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module strap_defaults_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reset_pin_low_i,
    input wire logic port1_speed_input_i,
    input wire logic port1_duplex_input_i,
    input wire logic port1_backpressure_input_i,
    input wire logic eeprom_present_i,
    input wire logic eeprom_load_i,
    input wire strap_defaults_pkg::strap_set_t eeprom_straps_i,
    input wire logic digital_reset_i,
    input wire logic reload_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [strap_defaults_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [strap_defaults_pkg::DAT_W-1:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_ack_o,
    input wire logic phy_rate_select_low_bit_o,
    input wire logic phy_half_full_bit_o,
    input wire logic port1_backpressure_enable_o,
    input wire logic port1_tx_pause_active_o,
    input wire logic port1_rx_pause_active_o
);
    import strap_defaults_pkg::*;
    logic hold_r;
    logic [2:0] lat_r;
    wire [2:0] outs = {phy_rate_select_low_bit_o, phy_half_full_bit_o, port1_backpressure_enable_o};
    wire [2:0] pins = {port1_speed_input_i, port1_duplex_input_i, port1_backpressure_input_i};
    wire ev = digital_reset_i || reload_i;
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = take && wb_we_i && !hold_r && !ev && !eeprom_load_i;
    ////////////////////////////////////////
    // hold_r high marks the release edge
    always_ff @(posedge clk_i) begin
        if (rst_i || !reset_pin_low_i) begin
            hold_r <= 1'b1;
        end else if (hold_r) begin
            hold_r <= 1'b0;
            lat_r <= pins;
        end
    end
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i || !reset_pin_low_i);
    property p_latch;
        hold_r && !eeprom_load_i |=> outs == $past(pins);
    endproperty
    a_latch: assert property (p_latch) else $error("strap latch");
    property p_manual;
        hold_r |=> !port1_tx_pause_active_o && !port1_rx_pause_active_o;
    endproperty
    a_manual: assert property (p_manual) else $error("pause active");
    property p_load;
        eeprom_load_i && !hold_r |=> outs == $past(eeprom_straps_i[3:1]);
    endproperty
    a_load: assert property (p_load) else $error("loader");
    property p_restore;
        ev && !hold_r && !eeprom_present_i && !eeprom_load_i |=> outs == lat_r;
    endproperty
    a_restore: assert property (p_restore) else $error("restore");
    property p_keep;
        ev && !hold_r && eeprom_present_i && !eeprom_load_i && !take |=> $stable(outs);
    endproperty
    a_keep: assert property (p_keep) else $error("event kept");
    property p_basic;
        wr && wb_adr_i == OFS_BASIC && wb_sel_i[1]
            |=> outs[2:1] == $past({wb_dat_i[13], wb_dat_i[8]});
    endproperty
    a_basic: assert property (p_basic) else $error("basic write");
    property p_flow;
        wr && wb_adr_i == OFS_FLOW && wb_sel_i[0]
            |=> {port1_tx_pause_active_o, port1_rx_pause_active_o} ==
                $past({2{wb_dat_i[3]}} & wb_dat_i[2:1]);
    endproperty
    a_flow: assert property (p_flow) else $error("flow write");
    property p_ack;
        take |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack");
endmodule // strap_defaults_assertions
bind port1_link_strap_defaults strap_defaults_assertions strap_defaults_assertions_i (.*);
`default_nettype wire

// >>> tb/strap_source.sv
// strap_source: strap pins and EEPROM loader in front of the strap block.
// assumes the bench calls its tasks; one clock.
`timescale 1ns/1ps
`default_nettype none
module strap_source (
    input wire logic clk_i,
    output var strap_defaults_pkg::strap_set_t pins_o,
    output var logic present_o,
    output var logic load_o,
    output var strap_defaults_pkg::strap_set_t straps_o
);
    import strap_defaults_pkg::*;
    initial begin
        pins_o = STRAP_TIE_OFF;
        present_o = 1'b0;
        load_o = 1'b0;
        straps_o = 4'h0;
    end
    task automatic drive_pins(input strap_set_t v);
        @(posedge clk_i);
        pins_o <= v;
    endtask
    task automatic set_present(input logic p);
        @(posedge clk_i);
        present_o <= p;
    endtask
    // loader data is gone after the beat: show its inverse
    task automatic load(input strap_set_t v);
        @(posedge clk_i);
        straps_o <= v;
        load_o <= 1'b1;
        @(posedge clk_i);
        load_o <= 1'b0;
        straps_o <= ~v;
    endtask
endmodule // strap_source
`default_nettype wire

// >>> tb/port1_link_strap_defaults_test.sv
// port1_link_strap_defaults_test: latch, loader, restore and writes.
// assumes the strap_source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module port1_link_strap_defaults_test;
    import strap_defaults_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, reset_pin_low_i = 1'b1;
    logic digital_reset_i = 1'b0, reload_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic [3:0] wb_sel_i = 4'h0;
    logic [3:0] lanes = 4'h3;
    logic wb_ack_o, phy_rate_select_low_bit_o, phy_half_full_bit_o;
    logic port1_backpressure_enable_o, port1_tx_pause_active_o, port1_rx_pause_active_o;
    logic pres, eld;
    strap_set_t pins, estr;
    int fails = 0, n_compared = 0, cycles = 0;
    strap_source strap_source_i (.clk_i, .pins_o(pins), .present_o(pres), .load_o(eld),
        .straps_o(estr));
    port1_link_strap_defaults port1_link_strap_defaults_i (.clk_i, .rst_i, .reset_pin_low_i,
        .port1_speed_input_i(pins.speed), .port1_duplex_input_i(pins.duplex),
        .port1_backpressure_input_i(pins.backpressure), .port1_pause_enable_input_i(pins.pause),
        .eeprom_present_i(pres), .eeprom_load_i(eld), .eeprom_straps_i(estr), .digital_reset_i,
        .reload_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o,
        .wb_ack_o, .phy_rate_select_low_bit_o, .phy_half_full_bit_o,
        .port1_backpressure_enable_o, .port1_tx_pause_active_o, .port1_rx_pause_active_o);
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= lanes;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic do_reset(input logic pin);
        @(posedge clk_i);
        if (pin) reset_pin_low_i <= 1'b0;
        else rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        reset_pin_low_i <= 1'b1;
        @(posedge clk_i);
    endtask
    task automatic pulse(input logic r);
        @(posedge clk_i);
        reload_i <= r;
        digital_reset_i <= !r;
        @(posedge clk_i);
        reload_i <= 1'b0;
        digital_reset_i <= 1'b0;
    endtask
    task automatic check_image(input strap_set_t s);
        wb(1'b0, OFS_BASIC, 32'h0);
        check(q, {18'h0, s.speed, 4'h0, s.duplex, 8'h00});
        wb(1'b0, OFS_ADVERT, 32'h0);
        check(q, {25'h0, s.duplex & ~s.speed, ~s.speed, 5'h01});
        wb(1'b0, OFS_MODES, 32'h0);
        check(q, {25'h0, s.speed, s.duplex, 5'h00});
        wb(1'b0, OFS_FLOW, 32'h0);
        check(q, {29'h0, s.pause, s.pause, s.backpressure});
    endtask
    ////////////////////////////////////////
    task automatic t_latch;
        logic [3:0] v [4] = '{4'hf, 4'ha, 4'h5, 4'h0};
        for (int i = 0; i < 4; i++) begin
            strap_source_i.drive_pins(strap_set_t'(v[i]));
            do_reset(i[0]);
            check_image(strap_set_t'(v[i]));
        end
    endtask
    task automatic t_eeprom;
        // live pins differ from the latched set, so a re-sample would show
        strap_source_i.drive_pins(4'hf);
        strap_source_i.set_present(1'b1);
        strap_source_i.load(4'h6);
        check_image(4'h6);
        pulse(1'b1);
        check_image(4'h6);
        strap_source_i.set_present(1'b0);
        pulse(1'b0);
        check_image(4'h0);
        strap_source_i.load(4'h9);
        check_image(4'h9);
        wb(1'b0, OFS_STATUS, 32'h0);
        check(q, 32'h0000_0090);
        wb(1'b1, OFS_CMD, 32'h2);
        check_image(4'h0);
        strap_source_i.load(4'h9);
        check_image(4'h9);
        wb(1'b1, OFS_CMD, 32'h1);
        check_image(4'h0);
        wb(1'b0, 8'h3c, 32'h0);
        check(q, 32'h0);
    endtask
    task automatic t_sw;
        wb(1'b1, OFS_FLOW, 32'hf);
        check({30'h0, port1_tx_pause_active_o, port1_rx_pause_active_o}, 32'h3);
        wb(1'b1, OFS_FLOW, 32'h6);
        check({30'h0, port1_tx_pause_active_o, port1_rx_pause_active_o}, 32'h0);
        wb(1'b1, OFS_BASIC, 32'h2000);
        check({30'h0, phy_rate_select_low_bit_o, phy_half_full_bit_o}, 32'h2);
        // low byte lane only: the upper byte must keep its value
        lanes = 4'h1;
        wb(1'b1, OFS_BASIC, 32'h0000_ffff);
        lanes = 4'h3;
        wb(1'b0, OFS_BASIC, 32'h0);
        check(q, 32'h0000_20ff);
        pulse(1'b0);
        check_image(4'h0);
    endtask
    task automatic complete_run;
        $display("fails=%0d n_compared=%0d", fails, n_compared);
        if (fails == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 4000) begin
            fails++;
            complete_run;
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_latch;
        t_eeprom;
        t_sw;
        complete_run;
    end
endmodule // port1_link_strap_defaults_test
`default_nettype wire
